/* design/pps_consts.svh */
`ifndef PPS_CONSTS_SVH
`define PPS_CONSTS_SVH

`define PPS_ADDR_W 12
`define PPS_NPIN 32
`define PPS_PSEL_W 5
`define PPS_VCNT_W 16

`define PPS_ACC_BASE 12'h000
`define PPS_ACC_MASK 12'hFC0
`define PPS_OFF_PINMASK 12'h040
`define PPS_OFF_VCOUNT 12'h044
`define PPS_OFF_DRV 12'h100
`define PPS_OFF_DRV_SET 12'h104
`define PPS_OFF_DRV_CLR 12'h108
`define PPS_OFF_IN 12'h10C
`define PPS_OFF_HEAD 12'h110
`define PPS_OFF_HEAD_SET 12'h114
`define PPS_OFF_HEAD_CLR 12'h118
`define PPS_OFF_LATCH 12'h11C
`define PPS_OFF_SENSE_SRC 12'h120
`define PPS_OFF_SSENSE_SRC 12'h124
`define PPS_CFG_BASE 12'h200
`define PPS_CFG_MASK 12'hF80

`define PPS_ACC_SEC_BIT 0
`define PPS_ACC_DMA_BIT 1
`define PPS_ACC_KIND_LSB 2
`define PPS_ACC_INDEP_BIT 4

`define PPS_ID_LSB 12
`define PPS_NS_NIBBLE 4'h4
`define PPS_S_NIBBLE 4'h5
`define PPS_PROT_NS_BIT 1
`define PPS_RESP_OKAY 2'b00
`define PPS_RESP_SLVERR 2'b10
`define PPS_DMA_SECURE 1'b1
`define PPS_SRC_LATCHED 1'b1

`endif

/* design/pps_pkg.sv */
package pps_pkg;
  typedef enum logic [1:0] {
    pps_ns_fixed,
    pps_sec_fixed,
    pps_user_sel,
    pps_split
  } pps_map_kind_type;
endpackage

/* design/pps_pin_gate.sv */
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_pin_gate #(
  parameter int NPERIPH = 8,
  parameter int NDOM = 2
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [`PPS_NPIN-1:0] pin_security_mask_i,
  input wire logic [NPERIPH-1:0] periph_secure_i,
  input wire logic [NPERIPH*`PPS_PSEL_W-1:0] psel_pin_i,
  input wire logic [NPERIPH-1:0] psel_conn_i,
  input wire logic [`PPS_NPIN-1:0] pin_in_i,
  input wire logic [NDOM-1:0] dom_secure_i,
  input wire logic [`PPS_NPIN-1:0] pin_detect_i,
  input wire logic [`PPS_NPIN-1:0] latch_i,
  input wire logic sense_source_select_i,
  input wire logic secure_sense_source_select_i,
  output logic [NPERIPH-1:0] psel_conn_o,
  output logic [NPERIPH-1:0] psel_value_o,
  output logic [NDOM*`PPS_NPIN-1:0] dom_pin_allow_o,
  output logic secure_sense_line_o,
  output logic nonsecure_sense_line_o
);
  logic [NPERIPH-1:0] conn_d;
  logic [NPERIPH-1:0] val_d;
  logic [NDOM*`PPS_NPIN-1:0] allow_d;
  wire [`PPS_NPIN-1:0] ssrc = (secure_sense_source_select_i == `PPS_SRC_LATCHED) ? latch_i :
                              pin_detect_i;
  wire [`PPS_NPIN-1:0] nsrc = (sense_source_select_i == `PPS_SRC_LATCHED) ? latch_i :
                              pin_detect_i;
  wire sec_line_d = |(ssrc & pin_security_mask_i);
  wire nsec_line_d = |(nsrc & ~pin_security_mask_i);

  for (genvar p = 0; p < NPERIPH; p++) begin : g_periph
    wire [`PPS_PSEL_W-1:0] sel = psel_pin_i[p*`PPS_PSEL_W +: `PPS_PSEL_W];
    wire ok = periph_secure_i[p] | ~pin_security_mask_i[sel];
    assign conn_d[p] = psel_conn_i[p] & ok;
    assign val_d[p] = psel_conn_i[p] & ok & pin_in_i[sel];

    a_psel_blocked: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
      !periph_secure_i[p] && pin_security_mask_i[sel] |=> !psel_conn_o[p] && !psel_value_o[p])
      else $error("Non-secure peripheral reached a secure pin.");
  end

  for (genvar d = 0; d < NDOM; d++) begin : g_dom
    // Secure domains see every pin, non-secure ones only the open pins.
    assign allow_d[d*`PPS_NPIN +: `PPS_NPIN] = dom_secure_i[d] ? '1 : ~pin_security_mask_i;
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      psel_conn_o <= '0;
      psel_value_o <= '0;
      dom_pin_allow_o <= '0;
      secure_sense_line_o <= 1'b0;
      nonsecure_sense_line_o <= 1'b0;
    end else begin
      psel_conn_o <= conn_d;
      psel_value_o <= val_d;
      dom_pin_allow_o <= allow_d;
      secure_sense_line_o <= sec_line_d;
      nonsecure_sense_line_o <= nsec_line_d;
    end
  end
endmodule

/* design/pps_filter.sv */
// Added by the designer: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pps_consts.svh"
module pps_filter
  import pps_pkg::*;
#(
  parameter int NPERIPH = 8,
  parameter int ID_W = 3,
  parameter int NDOM = 2,
  parameter int CFG_W = 8,
  parameter logic [2*NPERIPH-1:0] PERIPH_KIND = 16'hE4E4,
  parameter logic [NPERIPH-1:0] PERIPH_INDEP_DMA = 8'h44
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic [`PPS_ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic [2:0] s_axi_awprot_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [`PPS_ADDR_W-1:0] s_axi_araddr_i,
  input wire logic [2:0] s_axi_arprot_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic xfer_valid_i,
  input wire logic [31:0] xfer_addr_i,
  input wire logic xfer_nonsec_i,
  input wire logic xfer_secure_reg_i,
  input wire logic xfer_cpu_i,
  input wire logic xfer_err_cap_i,
  output logic xfer_pass_o,
  output logic [ID_W-1:0] xfer_id_o,
  output pps_pkg::pps_map_kind_type xfer_kind_o,
  output logic xfer_raz_o,
  output logic xfer_bus_err_o,
  output logic security_fault_exception_o,
  output logic peripheral_violation_event_o,
  output logic [NPERIPH-1:0] periph_secure_o,
  output logic [NPERIPH-1:0] periph_dma_secure_o,
  input wire logic [NPERIPH*`PPS_PSEL_W-1:0] psel_pin_i,
  input wire logic [NPERIPH-1:0] psel_conn_i,
  output logic [NPERIPH-1:0] psel_conn_o,
  output logic [NPERIPH-1:0] psel_value_o,
  input wire logic [NDOM-1:0] dom_secure_i,
  output logic [NDOM*`PPS_NPIN-1:0] dom_pin_allow_o,
  input wire logic [`PPS_NPIN-1:0] pin_in_i,
  input wire logic [`PPS_NPIN-1:0] pin_detect_i,
  output logic [`PPS_NPIN-1:0] gpio_out_o,
  output logic [`PPS_NPIN-1:0] gpio_dir_o,
  output logic [`PPS_NPIN*CFG_W-1:0] pad_cfg_o,
  output logic secure_sense_line_o,
  output logic nonsecure_sense_line_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  localparam logic [`PPS_NPIN-1:0] ALL_PINS = '1;

  logic [NPERIPH-1:0] sec_q, sec_d, dma_q, dma_d;
  logic [31:0] acc_rd [NPERIPH];
  logic [`PPS_NPIN-1:0] pin_mask_q, pin_mask_d, out_q, out_d, dir_q, dir_d, latch_q, latch_d;
  logic [CFG_W-1:0] cfg_q [`PPS_NPIN];
  logic nsel_q, nsel_d, ssel_q, ssel_d;
  logic bvalid_q, rvalid_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;
  logic [`PPS_VCNT_W-1:0] vcnt_q;
  logic pass_q, raz_q, err_q, fault_q, event_q;
  logic [ID_W-1:0] id_q;
  pps_map_kind_type kind_q;

  // Write side: address and data are taken together, one write in flight.
  wire wr_go = s_axi_awvalid_i & s_axi_wvalid_i & ~bvalid_q;
  wire ns_w = s_axi_awprot_i[`PPS_PROT_NS_BIT];
  wire [`PPS_ADDR_W-1:0] wa = {s_axi_awaddr_i[`PPS_ADDR_W-1:2], 2'b00};
  wire [31:0] strb_m = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                        {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
  wire [31:0] wm = strb_m & (ns_w ? ~pin_mask_q : ALL_PINS);
  wire [31:0] wbits = s_axi_wdata_i & wm;
  wire w_acc = ((wa & `PPS_ACC_MASK) == `PPS_ACC_BASE) && (32'(wa[5:2]) < NPERIPH);
  wire w_cfg = (wa & `PPS_CFG_MASK) == `PPS_CFG_BASE;
  wire [4:0] w_pin = wa[6:2];
  wire w_hit = w_acc | w_cfg | (wa == `PPS_OFF_PINMASK) | (wa == `PPS_OFF_VCOUNT) |
               ((wa >= `PPS_OFF_DRV) && (wa <= `PPS_OFF_SSENSE_SRC));
  wire wr_drv = wr_go & (wa == `PPS_OFF_DRV);
  wire wr_drv_set = wr_go & (wa == `PPS_OFF_DRV_SET);
  wire wr_drv_clr = wr_go & (wa == `PPS_OFF_DRV_CLR);
  wire wr_head = wr_go & (wa == `PPS_OFF_HEAD);
  wire wr_head_set = wr_go & (wa == `PPS_OFF_HEAD_SET);
  wire wr_head_clr = wr_go & (wa == `PPS_OFF_HEAD_CLR);
  wire wr_latch = wr_go & (wa == `PPS_OFF_LATCH);

  assign out_d = wr_drv ? ((out_q & ~wm) | wbits) : wr_drv_set ? (out_q | wbits) :
                 wr_drv_clr ? (out_q & ~wbits) : out_q;
  assign dir_d = wr_head ? ((dir_q & ~wm) | wbits) : wr_head_set ? (dir_q | wbits) :
                 wr_head_clr ? (dir_q & ~wbits) : dir_q;
  // A detect in the same cycle as a clearing write keeps the latch set.
  assign latch_d = (latch_q & ~(wr_latch ? wbits : '0)) | pin_detect_i;
  assign pin_mask_d = (wr_go & ~ns_w & (wa == `PPS_OFF_PINMASK)) ?
                      ((pin_mask_q & ~strb_m) | (s_axi_wdata_i & strb_m)) : pin_mask_q;
  assign nsel_d = (wr_go & (wa == `PPS_OFF_SENSE_SRC) & s_axi_wstrb_i[0]) ?
                  s_axi_wdata_i[0] : nsel_q;
  assign ssel_d = (wr_go & ~ns_w & (wa == `PPS_OFF_SSENSE_SRC) & s_axi_wstrb_i[0]) ?
                  s_axi_wdata_i[0] : ssel_q;

  for (genvar p = 0; p < NPERIPH; p++) begin : g_acc
    localparam pps_map_kind_type KIND = pps_map_kind_type'(PERIPH_KIND[2*p +: 2]);
    localparam logic CONFIGURABLE = (KIND == pps_user_sel) || (KIND == pps_split);
    localparam logic SEC_RST = (KIND != pps_ns_fixed);
    localparam logic INDEP = PERIPH_INDEP_DMA[p];
    wire hit = wr_go & ~ns_w & w_acc & (wa[5:2] == 4'(p)) & s_axi_wstrb_i[0];
    assign sec_d[p] = (hit & CONFIGURABLE) ? s_axi_wdata_i[`PPS_ACC_SEC_BIT] : sec_q[p];
    assign dma_d[p] = (hit & INDEP & sec_d[p]) ? s_axi_wdata_i[`PPS_ACC_DMA_BIT] : dma_q[p];
    assign periph_dma_secure_o[p] = (INDEP & sec_q[p]) ? dma_q[p] : sec_q[p];
    assign acc_rd[p] = {27'h0, INDEP, KIND, dma_q[p], sec_q[p]};
    always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
        sec_q[p] <= SEC_RST;
        dma_q[p] <= `PPS_DMA_SECURE;
      end else begin
        sec_q[p] <= sec_d[p];
        dma_q[p] <= dma_d[p];
      end
    end
  end
  assign periph_secure_o = sec_q;

  for (genvar i = 0; i < `PPS_NPIN; i++) begin : g_cfg
    wire hit = wr_go & w_cfg & (w_pin == 5'(i)) & ~(ns_w & pin_mask_q[i]);
    always_ff @(posedge ref_clk_i) begin
      if (!rstn_i) begin
        cfg_q[i] <= '0;
      end else if (hit) begin
        cfg_q[i] <= (cfg_q[i] & ~strb_m[CFG_W-1:0]) | (s_axi_wdata_i[CFG_W-1:0] & strb_m[CFG_W-1:0]);
      end
    end
    assign pad_cfg_o[i*CFG_W +: CFG_W] = cfg_q[i];
  end

  // Read side: non-secure reads see zero in every secure pin position.
  wire rd_go = s_axi_arvalid_i & ~rvalid_q;
  wire ns_r = s_axi_arprot_i[`PPS_PROT_NS_BIT];
  wire [`PPS_ADDR_W-1:0] ra = {s_axi_araddr_i[`PPS_ADDR_W-1:2], 2'b00};
  wire [31:0] rm = ns_r ? ~pin_mask_q : ALL_PINS;
  wire r_acc = ((ra & `PPS_ACC_MASK) == `PPS_ACC_BASE) && (32'(ra[5:2]) < NPERIPH);
  wire r_cfg = (ra & `PPS_CFG_MASK) == `PPS_CFG_BASE;
  wire [4:0] r_pin = ra[6:2];
  wire r_drv = (ra == `PPS_OFF_DRV) | (ra == `PPS_OFF_DRV_SET) | (ra == `PPS_OFF_DRV_CLR);
  wire r_head = (ra == `PPS_OFF_HEAD) | (ra == `PPS_OFF_HEAD_SET) | (ra == `PPS_OFF_HEAD_CLR);
  wire r_hit = r_acc | r_cfg | (ra == `PPS_OFF_PINMASK) | (ra == `PPS_OFF_VCOUNT) |
               ((ra >= `PPS_OFF_DRV) && (ra <= `PPS_OFF_SSENSE_SRC));
  wire [31:0] cfg_rd = (ns_r & pin_mask_q[r_pin]) ? '0 : 32'(cfg_q[r_pin]);
  wire [31:0] rd_val =
    r_acc ? (ns_r ? '0 : acc_rd[ra[2 +: ID_W]]) :
    (ra == `PPS_OFF_PINMASK) ? (ns_r ? '0 : pin_mask_q) :
    (ra == `PPS_OFF_VCOUNT) ? 32'(vcnt_q) :
    r_drv ? (out_q & rm) :
    (ra == `PPS_OFF_IN) ? (pin_in_i & rm) :
    r_head ? (dir_q & rm) :
    (ra == `PPS_OFF_LATCH) ? (latch_q & rm) :
    (ra == `PPS_OFF_SENSE_SRC) ? {31'h0, nsel_q} :
    (ra == `PPS_OFF_SSENSE_SRC) ? {31'h0, ssel_q & ~ns_r} :
    r_cfg ? cfg_rd : '0;

  assign s_axi_awready_o = wr_go;
  assign s_axi_wready_o = wr_go;
  assign s_axi_arready_o = ~rvalid_q;
  assign s_axi_bvalid_o = bvalid_q;
  assign s_axi_bresp_o = bresp_q;
  assign s_axi_rvalid_o = rvalid_q;
  assign s_axi_rresp_o = rresp_q;
  assign s_axi_rdata_o = rdata_q;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      bvalid_q <= 1'b0;
      bresp_q <= `PPS_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= w_hit ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      rvalid_q <= 1'b0;
      rresp_q <= `PPS_RESP_OKAY;
      rdata_q <= '0;
    end else if (rd_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= r_hit ? `PPS_RESP_OKAY : `PPS_RESP_SLVERR;
      rdata_q <= rd_val;
    end else if (s_axi_rready_i) begin
      rvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pin_mask_q <= '0;
      out_q <= '0;
      dir_q <= '0;
      latch_q <= '0;
      nsel_q <= 1'b0;
      ssel_q <= 1'b0;
    end else begin
      pin_mask_q <= pin_mask_d;
      out_q <= out_d;
      dir_q <= dir_d;
      latch_q <= latch_d;
      nsel_q <= nsel_d;
      ssel_q <= ssel_d;
    end
  end
  assign gpio_out_o = out_q;
  assign gpio_dir_o = dir_q;

  // Transfer filter: alias decode by top nibble, then attribute checks.
  wire [3:0] nib = xfer_addr_i[31:28];
  wire in4 = nib == `PPS_NS_NIBBLE;
  wire in5 = nib == `PPS_S_NIBBLE;
  wire [ID_W-1:0] xid = xfer_addr_i[`PPS_ID_LSB +: ID_W];
  pps_map_kind_type xkind;
  assign xkind = pps_map_kind_type'(PERIPH_KIND[{xid, 1'b0} +: 2]);
  wire xsec = sec_q[xid];
  wire sec_viol = in5 & xfer_nonsec_i;
  wire mapped = (xkind == pps_ns_fixed) ? in4 :
                (xkind == pps_sec_fixed) ? in5 :
                (xkind == pps_user_sel) ? (xsec ? in5 : in4) :
                (xsec ? in5 : (in4 | in5));
  wire viol = xfer_valid_i & (sec_viol | ~mapped);
  // Secure registers of a non-secure split peripheral are hidden behind the open alias for every requester.
  wire split_raz = xfer_valid_i & ~viol & (xkind == pps_split) & ~xsec & in4 &
                   xfer_secure_reg_i;

  always_ff @(posedge ref_clk_i) begin
    if (!rstn_i) begin
      pass_q <= 1'b0;
      raz_q <= 1'b0;
      err_q <= 1'b0;
      fault_q <= 1'b0;
      event_q <= 1'b0;
      id_q <= '0;
      kind_q <= pps_ns_fixed;
      vcnt_q <= '0;
    end else begin
      pass_q <= xfer_valid_i & ~viol & ~split_raz;
      raz_q <= viol | split_raz;
      err_q <= viol & xfer_err_cap_i;
      fault_q <= xfer_valid_i & sec_viol & xfer_cpu_i;
      event_q <= viol;
      id_q <= xid;
      kind_q <= xkind;
      vcnt_q <= vcnt_q + `PPS_VCNT_W'(viol);
    end
  end
  assign xfer_pass_o = pass_q;
  assign xfer_raz_o = raz_q;
  assign xfer_bus_err_o = err_q;
  assign security_fault_exception_o = fault_q;
  assign peripheral_violation_event_o = event_q;
  assign xfer_id_o = id_q;
  assign xfer_kind_o = kind_q;

  pps_pin_gate #(
    .NPERIPH(NPERIPH),
    .NDOM(NDOM)
  ) u_pin_gate (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .pin_security_mask_i(pin_mask_q),
    .periph_secure_i(sec_q),
    .psel_pin_i(psel_pin_i),
    .psel_conn_i(psel_conn_i),
    .pin_in_i(pin_in_i),
    .dom_secure_i(dom_secure_i),
    .pin_detect_i(pin_detect_i),
    .latch_i(latch_q),
    .sense_source_select_i(nsel_q),
    .secure_sense_source_select_i(ssel_q),
    .psel_conn_o(psel_conn_o),
    .psel_value_o(psel_value_o),
    .dom_pin_allow_o(dom_pin_allow_o),
    .secure_sense_line_o(secure_sense_line_o),
    .nonsecure_sense_line_o(nonsecure_sense_line_o)
  );

  logic [NPERIPH-1:0] sec_rst_vec;
  localparam logic [NPERIPH-1:0] ALL_PERIPH = '1;
  for (genvar p = 0; p < NPERIPH; p++) begin : g_rst_vec
    assign sec_rst_vec[p] = (PERIPH_KIND[2*p +: 2] != 2'(pps_ns_fixed));
  end

  a_alias_fault: assert property (xfer_valid_i && in5 && xfer_nonsec_i && xfer_cpu_i |=>
    security_fault_exception_o && !xfer_pass_o && xfer_raz_o)
    else $error("Non-secure alias access did not fault.");
  a_viol_event_pair: assert property (xfer_valid_i && viol |=>
    peripheral_violation_event_o ##1 !peripheral_violation_event_o || $past(viol))
    else $error("Violation event missing or stretched.");
  a_viol_blocks: assert property (peripheral_violation_event_o |->
    xfer_raz_o && !xfer_pass_o && (xfer_bus_err_o == $past(xfer_err_cap_i)))
    else $error("Violation not blocked as required.");
  a_fixed_decode: assert property (xfer_valid_i && !xfer_nonsec_i && xkind == pps_sec_fixed &&
    in4 |=> !xfer_pass_o && peripheral_violation_event_o)
    else $error("Fixed secure peripheral decoded in open alias.");
  a_split_hidden: assert property (split_raz |=> xfer_raz_o && !xfer_bus_err_o &&
    !peripheral_violation_event_o && !security_fault_exception_o)
    else $error("Hidden split register not read-as-zero.");
  a_reset_secure: assert property ($rose(rstn_i) |->
    (periph_secure_o | ~sec_rst_vec) == ALL_PERIPH && periph_dma_secure_o == periph_secure_o)
    else $error("Peripheral not secure after reset.");
  a_ns_drv_kept: assert property (wr_go && ns_w && (wr_drv || wr_drv_set || wr_drv_clr) |=>
    (out_q & pin_mask_q) == ($past(out_q) & $past(pin_mask_q)))
    else $error("Non-secure write changed a secure pin.");
  a_ns_read_zero: assert property (rd_go && ns_r && (r_drv || r_head) |=>
    (s_axi_rdata_o & $past(pin_mask_q)) == '0 && s_axi_rresp_o == `PPS_RESP_OKAY)
    else $error("Non-secure read exposed a secure pin.");
  a_ssense_raz: assert property (rd_go && ns_r && ra == `PPS_OFF_SSENSE_SRC |=>
    s_axi_rdata_o == '0)
    else $error("Secure sense select visible to non-secure read.");

endmodule

/* tb/pps_master.sv */
`timescale 1ns/1ps
module pps_master (
  input wire logic ref_clk_i,
  output logic xfer_valid_o,
  output logic [31:0] xfer_addr_o,
  output logic [3:0] xfer_attr_o
);
  initial begin
    xfer_valid_o = 1'b0;
    xfer_addr_o = 32'h0000_0000;
    xfer_attr_o = 4'h0;
  end

  // One transfer per call, attributes ordered non-secure, secure register, processor, error capable.
  // Fields mean nothing once valid drops, so they are inverted rather than left looking live.
  task automatic send(input logic [31:0] a, input logic [3:0] f);
    @(posedge ref_clk_i);
    xfer_valid_o <= 1'b1;
    xfer_addr_o <= a;
    xfer_attr_o <= f;
    @(posedge ref_clk_i);
    xfer_valid_o <= 1'b0;
    xfer_addr_o <= ~a;
    xfer_attr_o <= ~f;
  endtask
endmodule

/* tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  import pps_pkg::*;
  typedef struct packed {logic [31:0] a; logic [3:0] f; logic [4:0] e;} pps_row_type;
  // Expected outcome bits are pass, zeroed read, bus error, security fault, violation event.
  localparam pps_row_type ROWS [0:15] = '{
    '{32'h4000_0000, 4'h8, 5'h10}, '{32'h5000_0000, 4'h0, 5'h09}, '{32'h5000_1000, 4'h0, 5'h10},
    '{32'h4000_1000, 4'h9, 5'h0D}, '{32'h5000_1000, 4'hB, 5'h0F}, '{32'h5000_2000, 4'h0, 5'h10},
    '{32'h4000_2000, 4'h0, 5'h09}, '{32'h5000_3000, 4'h4, 5'h10}, '{32'h5000_3000, 4'hA, 5'h0B},
    '{32'h6000_0000, 4'h1, 5'h0D}, '{32'h4000_2000, 4'h8, 5'h10}, '{32'h4000_3000, 4'h8, 5'h10},
    '{32'h5000_3000, 4'h4, 5'h10}, '{32'h5000_2000, 4'h0, 5'h09},
    '{32'h4000_3000, 4'hC, 5'h08}, '{32'h4000_1000, 4'h0, 5'h09}};
  localparam logic [15:0] KIND = 16'hE4E4;
  logic ref_clk_i, rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
  logic s_axi_rready_i, s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, xfer_valid_i, xfer_nonsec_i, xfer_secure_reg_i, xfer_cpu_i;
  logic xfer_err_cap_i, xfer_pass_o, xfer_raz_o, xfer_bus_err_o, security_fault_exception_o;
  logic peripheral_violation_event_o, secure_sense_line_o, nonsecure_sense_line_o;
  logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [2:0] s_axi_awprot_i, s_axi_arprot_i, xfer_id_o;
  logic [3:0] s_axi_wstrb_i, xfer_attr;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, dom_secure_i, resp;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, pin_in_i, pin_detect_i, gpio_out_o, gpio_dir_o;
  logic [31:0] xfer_addr_i, rd;
  logic [7:0] periph_secure_o, periph_dma_secure_o, psel_conn_i, psel_conn_o, psel_value_o;
  logic [39:0] psel_pin_i;
  logic [63:0] dom_pin_allow_o;
  logic [255:0] pad_cfg_o;
  pps_map_kind_type xfer_kind_o;
  int n_fail = 0;
  int compares = 0;

  assign {xfer_nonsec_i, xfer_secure_reg_i, xfer_cpu_i, xfer_err_cap_i} = xfer_attr;
  pps_filter i_dut (.*);
  pps_master i_mst (.ref_clk_i(ref_clk_i), .xfer_valid_o(xfer_valid_i),
    .xfer_addr_o(xfer_addr_i), .xfer_attr_o(xfer_attr));

  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end

  task automatic give_verdict();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask

  // Address and data are offered together; the slave takes both at one edge.
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic ns);
    @(posedge ref_clk_i);
    s_axi_awaddr_i <= a;
    s_axi_awprot_i <= {1'b0, ns, 1'b0};
    s_axi_wdata_i <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do @(posedge ref_clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    do @(posedge ref_clk_i); while (!s_axi_bvalid_o);
    resp = s_axi_bresp_o;
    s_axi_bready_i <= 1'b0;
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic ns);
    @(posedge ref_clk_i);
    s_axi_araddr_i <= a;
    s_axi_arprot_i <= {1'b0, ns, 1'b0};
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge ref_clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge ref_clk_i); while (!s_axi_rvalid_o);
    rd = s_axi_rdata_o;
    resp = s_axi_rresp_o;
    s_axi_rready_i <= 1'b0;
  endtask

  task automatic run_rows(input int lo, input int hi);
    for (int i = lo; i <= hi; i++) begin
      i_mst.send(ROWS[i].a, ROWS[i].f);
      #1;
      chk("xfer", {xfer_pass_o, xfer_raz_o, xfer_bus_err_o, security_fault_exception_o,
        peripheral_violation_event_o}, ROWS[i].e);
      chk("id", xfer_id_o, ROWS[i].a[14:12]);
      chk("kind", xfer_kind_o, KIND[2*ROWS[i].a[14:12] +: 2]);
    end
  endtask

  initial begin
    repeat (5000) @(posedge ref_clk_i);
    n_fail++;
    give_verdict();
  end

  initial begin
    {rstn_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i} = '0;
    {s_axi_rready_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_awprot_i, s_axi_arprot_i} = '0;
    s_axi_wdata_i = 32'h0000_0000;
    s_axi_wstrb_i = 4'hF;
    pin_in_i = 32'hFFFF_FFFF;
    pin_detect_i = 32'h0000_0001;
    dom_secure_i = 2'b01;
    psel_pin_i = 40'h00_0010_0000;
    psel_conn_i = 8'h13;
    repeat (16) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    #1;
    chk("psec", periph_secure_o, 8'hEE);
    chk("dsec", periph_dma_secure_o, 8'hEE);
    axi_rd(12'h008, 1'b0);
    chk("acc2", rd, 32'h0000_001B);
    axi_rd(12'h300, 1'b0);
    chk("unmapped", resp, 2'b10);
    run_rows(0, 9);
    axi_wr(12'h000, 32'h0000_0001, 1'b0);
    chk("psec0", periph_secure_o[0], 1'b0);
    axi_wr(12'h008, 32'h0000_0001, 1'b0);
    chk("dma2", {periph_secure_o[2], periph_dma_secure_o[2]}, 2'b10);
    axi_wr(12'h008, 32'h0000_0000, 1'b0);
    axi_wr(12'h00C, 32'h0000_0000, 1'b0);
    chk("psec23", periph_secure_o[3:2], 2'b00);
    run_rows(10, 15);
    axi_wr(12'h040, 32'h0000_0001, 1'b0);
    axi_wr(12'h100, 32'h0000_0001, 1'b0);
    axi_wr(12'h100, 32'h0000_0002, 1'b1);
    chk("bresp_ns", resp, 2'b00);
    chk("out", gpio_out_o, 32'h0000_0003);
    axi_rd(12'h100, 1'b1);
    chk("out_ns", rd, 32'h0000_0002);
    axi_wr(12'h200, 32'h0000_00FF, 1'b1);
    chk("cfg0", pad_cfg_o[7:0], 8'h00);
    axi_wr(12'h200, 32'h0000_005A, 1'b0);
    chk("cfg0_s", pad_cfg_o[7:0], 8'h5A);
    axi_rd(12'h200, 1'b1);
    chk("cfg0_ns", rd, 32'h0000_0000);
    axi_wr(12'h114, 32'h0000_0003, 1'b1);
    chk("dir", gpio_dir_o, 32'h0000_0002);
    repeat (2) @(posedge ref_clk_i);
    #1;
    chk("conn", psel_conn_o, 8'h12);
    chk("value", psel_value_o, 8'h12);
    chk("dom", dom_pin_allow_o, 64'hFFFF_FFFE_FFFF_FFFF);
    chk("sense", {secure_sense_line_o, nonsecure_sense_line_o}, 2'b10);
    axi_wr(12'h120, 32'h0000_0001, 1'b1);
    pin_detect_i <= 32'h0000_0005;
    @(posedge ref_clk_i);
    pin_detect_i <= 32'h0000_0001;
    repeat (3) @(posedge ref_clk_i);
    #1;
    chk("sense_latched", {secure_sense_line_o, nonsecure_sense_line_o}, 2'b11);
    axi_wr(12'h124, 32'h0000_0001, 1'b0);
    axi_wr(12'h124, 32'h0000_0000, 1'b1);
    axi_rd(12'h124, 1'b1);
    chk("ssel_ns", rd, 32'h0000_0000);
    axi_rd(12'h124, 1'b0);
    chk("ssel_s", rd, 32'h0000_0001);
    give_verdict();
  end
endmodule
